// >>> alarm_state_encoder.sv
// Registered encoder of the insulation alarm status word
module alarm_state_encoder (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        alarm_insul,
    input  wire logic        alarm_prevent,
    input  wire logic        alarm_transient,
    input  wire logic        alarm_acked,
    output logic [15:0]      code_q
);
    import trend_readout_pkg::*;

    logic [15:0] code_d;

    // One code at a time; an acknowledged alarm outranks the live ones
    always_comb begin
        if (alarm_acked) begin
            code_d = ALARM_ACKED;
        end else if (alarm_insul) begin
            code_d = ALARM_ACTIVE;
        end else if (alarm_prevent) begin
            code_d = ALARM_PREVENT;
        end else if (alarm_transient) begin
            code_d = ALARM_TRANS;
        end else begin
            code_d = ALARM_NONE;
        end
    end

    // Status word register
    always_ff @(posedge clk) begin
        if (rst) begin
            code_q <= ALARM_NONE;
        end else begin
            code_q <= code_d;
        end
    end

endmodule

// >>> alarm_status_trend_readout.sv
// Register readout of the insulation alarm status and of the five trend logs
//////////////////////////////////////////////////////////////////////////////////////////////////////
//
// Function
// - Alarm word reads 0 none, 1 alarm, 2 preventive, 4 transient, 8 acknowledged.
// - Hour pending count is a read-only word of unread hourly records.
// - Day, week, month, year pending counts count their own unread records.
// - Reading the hour value delivers the next record and lowers its count.
// - Reading the day value delivers the next record and lowers its count.
// - Reading the week value delivers the next record and lowers its count.
// - Reading the month value delivers the next record and lowers its count.
// - Reading the year value delivers the next record and lowers the year count.
// - Day to year record status codes run 0 to 5.
// - Hour record status uses the same codes 0 to 5.
module alarm_status_trend_readout (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    input  wire logic                                 alarm_insul,
    input  wire logic                                 alarm_prevent,
    input  wire logic                                 alarm_transient,
    input  wire logic                                 alarm_acked,
    input  wire logic [trend_readout_pkg::NUM_RES-1:0] rec_push,
    input  wire logic [31:0]                          rec_value,
    input  wire logic [2:0]                           rec_state,
    input  wire logic                                 rd_req,
    input  wire logic [15:0]                          rd_addr,
    output logic [15:0]                               rd_data_q,
    output logic                                      rd_valid_q,
    output logic                                      rd_err_q
);
    import trend_readout_pkg::*;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [15:0] alarm_code_w;
    logic [15:0] cnt_w      [NUM_RES];
    logic [31:0] head_val_w [NUM_RES];
    logic [2:0]  head_st_w  [NUM_RES];
    logic [31:0] last_val_q [NUM_RES];
    logic [2:0]  last_st_q  [NUM_RES];
    logic        pop_w      [NUM_RES];
    logic        rd_hit_d;
    logic [15:0] rd_word_d;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Alarm status

    alarm_state_encoder u_alarm (
        .clk             (clk),
        .rst             (rst),
        .alarm_insul     (alarm_insul),
        .alarm_prevent   (alarm_prevent),
        .alarm_transient (alarm_transient),
        .alarm_acked     (alarm_acked),
        .code_q          (alarm_code_w)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Trend logs, one slice per resolution

    genvar gi;
    generate
        for (gi = 0; gi < NUM_RES; gi++) begin : g_res
            // read of the high value word consumes a record
            assign pop_w[gi] = rd_req && (rd_addr == VAL_OFS[gi]);

            trend_record_store u_store (
                .clk        (clk),
                .rst        (rst),
                .push       (rec_push[gi]),
                .push_value (rec_value),
                .push_state (rec_state),
                .pop        (pop_w[gi]),
                .head_value (head_val_w[gi]),
                .head_state (head_st_w[gi]),
                .count_q    (cnt_w[gi])
            );

            // hold the record just delivered
            // The low word and status are served from here, so a record pushed between the
            // two word reads can never tear the float or mismatch the status
            always_ff @(posedge clk) begin
                if (rst) begin
                    last_val_q[gi] <= VAL_RST;
                    last_st_q[gi]  <= REC_UNINIT;
                end else if (pop_w[gi] && (cnt_w[gi] != CNT_RST)) begin
                    last_val_q[gi] <= head_val_w[gi];
                    last_st_q[gi]  <= head_st_w[gi];
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Register read decode

    // Address decode and word select; an empty log repeats the last record delivered
    always_comb begin
        rd_hit_d  = 1'b0;
        rd_word_d = 16'h0000;
        if (rd_addr == ALARM_OFS) begin
            rd_hit_d  = 1'b1;
            rd_word_d = alarm_code_w;
        end
        for (int i = 0; i < NUM_RES; i++) begin
            if (rd_addr == CNT_OFS[i]) begin
                rd_hit_d  = 1'b1;
                rd_word_d = cnt_w[i];
            end
            if (rd_addr == VAL_OFS[i]) begin
                rd_hit_d  = 1'b1;
                rd_word_d = (cnt_w[i] != CNT_RST) ? head_val_w[i][31:16] : last_val_q[i][31:16];
            end
            if (rd_addr == (VAL_OFS[i] + LO_STEP)) begin
                rd_hit_d  = 1'b1;
                rd_word_d = last_val_q[i][15:0];
            end
            // status word right after its value window
            if (rd_addr == ST_OFS[i]) begin
                rd_hit_d  = 1'b1;
                rd_word_d = {13'h0000, last_st_q[i]};
            end
        end
    end

    // Answer registers; data holds between reads, unmapped reads answer zero with an error
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
            rd_err_q   <= 1'b0;
        end else begin
            rd_valid_q <= rd_req;
            rd_err_q   <= rd_req && !rd_hit_d;
            if (rd_req) begin
                rd_data_q <= rd_hit_d ? rd_word_d : 16'h0000;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks

    // Alarm code follows the alarm inputs one cycle later
    property p_alarm_code;
        @(posedge clk) disable iff (rst)
        !$past(rst) |->
            ($past(alarm_acked) ? alarm_code_w == ALARM_ACKED :
             $past(alarm_insul) ? alarm_code_w == ALARM_ACTIVE :
             $past(alarm_prevent) ? alarm_code_w == ALARM_PREVENT :
             $past(alarm_transient) ? alarm_code_w == ALARM_TRANS :
             alarm_code_w == ALARM_NONE);
    endproperty
    a_alarm_code: assert property (p_alarm_code) else $error("alarm code does not match inputs");

    // Alarm register read returns the encoder word
    property p_alarm_read;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == ALARM_OFS) |=> (rd_valid_q && !rd_err_q && rd_data_q == $past(alarm_code_w));
    endproperty
    a_alarm_read: assert property (p_alarm_read) else $error("alarm read returned wrong word");

    // Hour count read shows the pending count
    property p_hour_count;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == CNT_OFS[0]) |=> (rd_data_q == $past(cnt_w[0]));
    endproperty
    a_hour_count: assert property (p_hour_count) else $error("hour count read wrong");

    // Year count read shows the pending count
    property p_year_count;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == CNT_OFS[4]) |=> (rd_data_q == $past(cnt_w[4]));
    endproperty
    a_year_count: assert property (p_year_count) else $error("year count read wrong");

    // Hour value read delivers the head record
    property p_hour_deliver;
        @(posedge clk) disable iff (rst)
        (pop_w[0] && cnt_w[0] != CNT_RST) |=>
            (rd_data_q == $past(head_val_w[0][31:16]) && last_val_q[0] == $past(head_val_w[0]));
    endproperty
    a_hour_deliver: assert property (p_hour_deliver) else $error("hour record not delivered");

    // Day value read lowers the day count by one when nothing arrives
    property p_day_dec;
        @(posedge clk) disable iff (rst)
        (pop_w[1] && cnt_w[1] != CNT_RST && !rec_push[1]) |=> (cnt_w[1] == $past(cnt_w[1]) - 16'h0001);
    endproperty
    a_day_dec: assert property (p_day_dec) else $error("day count not lowered");

    // Week and month value reads lower their counts
    property p_week_dec;
        @(posedge clk) disable iff (rst)
        (pop_w[2] && cnt_w[2] != CNT_RST && !rec_push[2]) |=> (cnt_w[2] == $past(cnt_w[2]) - 16'h0001);
    endproperty
    a_week_dec: assert property (p_week_dec) else $error("week count not lowered");

    property p_month_dec;
        @(posedge clk) disable iff (rst)
        (pop_w[3] && cnt_w[3] != CNT_RST && !rec_push[3]) |=> (cnt_w[3] == $past(cnt_w[3]) - 16'h0001);
    endproperty
    a_month_dec: assert property (p_month_dec) else $error("month count not lowered");

    // Year value read lowers the year count and leaves the month count alone
    property p_year_dec;
        @(posedge clk) disable iff (rst)
        (pop_w[4] && cnt_w[4] != CNT_RST && !rec_push[4] && !rec_push[3])
            |=> (cnt_w[4] == $past(cnt_w[4]) - 16'h0001 && cnt_w[3] == $past(cnt_w[3]));
    endproperty
    a_year_dec: assert property (p_year_dec) else $error("year count not lowered");

    // Hour, day and year status reads never show a code outside 0 to 5
    property p_state_range;
        @(posedge clk) disable iff (rst)
        (rd_req && (rd_addr == ST_OFS[0] || rd_addr == ST_OFS[1] || rd_addr == ST_OFS[4]))
            |=> (rd_data_q <= {13'h0000, REC_SUPPLY_INJ} && !rd_err_q);
    endproperty
    a_state_range: assert property (p_state_range) else $error("record status out of range");

    // Hour status read after a pop shows the stored code
    property p_hour_state;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == ST_OFS[0]) |=> (rd_data_q == {13'h0000, $past(last_st_q[0])});
    endproperty
    a_hour_state: assert property (p_hour_state) else $error("hour status read wrong");

    // Addresses between count block and value windows are unmapped
    property p_gap_err;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == 16'h04b5) |=> (rd_err_q && rd_data_q == 16'h0000);
    endproperty
    a_gap_err: assert property (p_gap_err) else $error("unmapped read not refused");

    // Empty week log stays at zero when read
    property p_no_wrap;
        @(posedge clk) disable iff (rst)
        (pop_w[2] && cnt_w[2] == CNT_RST && !rec_push[2]) |=> (cnt_w[2] == CNT_RST);
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("pending count wrapped");

    // Status read, polled every other cycle after value, count and low word reads, shows the status of the popped record
    sequence s_day_pop;
        pop_w[1] && cnt_w[1] != CNT_RST;
    endsequence
    sequence s_day_cnt;
        rd_req && rd_addr == CNT_OFS[1];
    endsequence
    sequence s_day_lo;
        rd_req && rd_addr == (VAL_OFS[1] + LO_STEP);
    endsequence
    sequence s_day_st;
        rd_req && rd_addr == ST_OFS[1];
    endsequence
    property p_same_record;
        @(posedge clk) disable iff (rst)
        s_day_pop ##2 s_day_cnt ##2 s_day_lo ##2 s_day_st
            |=> (rd_data_q == {13'h0000, $past(head_st_w[1], 7)});
    endproperty
    a_same_record: assert property (p_same_record) else $error("status from a different record");

    // Reset leaves the answer port quiet and the hour log empty
    property p_reset_idle;
        @(posedge clk)
        rst |=> (!rd_valid_q && !rd_err_q && rd_data_q == 16'h0000 && cnt_w[0] == CNT_RST);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset state wrong");

    // Every read is answered on the next edge
    property p_answer;
        @(posedge clk) disable iff (rst)
        rd_req |=> rd_valid_q;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");

    // No answer without a request
    property p_no_spurious;
        @(posedge clk) disable iff (rst)
        !rd_req |=> (!rd_valid_q && !rd_err_q);
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");

    // Read data holds between answers
    property p_data_hold;
        @(posedge clk) disable iff (rst)
        !rd_req |=> $stable(rd_data_q);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data changed while idle");

    // An error answer carries zero data
    property p_err_zero;
        @(posedge clk) disable iff (rst)
        rd_err_q |-> (rd_valid_q && rd_data_q == 16'h0000);
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer with data");

    // Hour push raises the count when the ring is neither full nor read
    property p_hour_push;
        @(posedge clk) disable iff (rst)
        (rec_push[0] && !pop_w[0] && cnt_w[0] != RING_FULL) |=> (cnt_w[0] == $past(cnt_w[0]) + 16'h0001);
    endproperty
    a_hour_push: assert property (p_hour_push) else $error("hour count not raised");

    // A push into a full ring keeps the count at the cap
    property p_full_hold;
        @(posedge clk) disable iff (rst)
        (rec_push[0] && !pop_w[0] && cnt_w[0] == RING_FULL) |=> (cnt_w[0] == RING_FULL);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full count moved");

    // Hour and year counts never pass the ring depth
    property p_count_cap;
        @(posedge clk) disable iff (rst)
        (cnt_w[0] <= RING_FULL) && (cnt_w[4] <= RING_FULL);
    endproperty
    a_count_cap: assert property (p_count_cap) else $error("count above ring depth");

    // Day and month count reads show their own counts
    property p_day_count;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == CNT_OFS[1]) |=> (rd_data_q == $past(cnt_w[1]));
    endproperty
    a_day_count: assert property (p_day_count) else $error("day count read wrong");

    property p_month_count;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == CNT_OFS[3]) |=> (rd_data_q == $past(cnt_w[3]));
    endproperty
    a_month_count: assert property (p_month_count) else $error("month count read wrong");

    // Hour low word comes from the record last delivered
    property p_hour_low;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == (VAL_OFS[0] + LO_STEP)) |=> (rd_data_q == $past(last_val_q[0][15:0]));
    endproperty
    a_hour_low: assert property (p_hour_low) else $error("hour low word wrong");

    // Empty hour log repeats the last delivered high word
    property p_hour_empty;
        @(posedge clk) disable iff (rst)
        (pop_w[0] && cnt_w[0] == CNT_RST) |=> (rd_data_q == $past(last_val_q[0][31:16]));
    endproperty
    a_hour_empty: assert property (p_hour_empty) else $error("empty hour read wrong");

    // Year status read shows the stored code
    property p_year_state;
        @(posedge clk) disable iff (rst)
        (rd_req && rd_addr == ST_OFS[4]) |=> (rd_data_q == {13'h0000, $past(last_st_q[4])});
    endproperty
    a_year_state: assert property (p_year_state) else $error("year status read wrong");

endmodule

// >>> master_poll_model.sv
// Polling master model that issues single-register reads to the readout block
module master_poll_model (
    input  wire logic        clk,
    output logic             rd_req,
    output logic [15:0]      rd_addr,
    input  wire logic [15:0] rd_data_q,
    input  wire logic        rd_valid_q,
    input  wire logic        rd_err_q
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////
    // Bus idle from time zero
    initial begin
        rd_req  = 1'b0;
        rd_addr = 16'h0000;
    end

    // One read, answer packed as {seen, err, data}; gap idles first to act as a slow poller.
    // The address is inverted once released so a stale address never looks like a request
    task automatic read_reg(input logic [15:0] addr, input int gap, output logic [17:0] ans);
        int n;
        ans = 18'h00000;
        n = 0;
        repeat (gap) @(negedge clk);
        @(negedge clk);
        rd_req  = 1'b1;
        rd_addr = addr;
        @(negedge clk);
        rd_req  = 1'b0;
        rd_addr = ~addr;
        // The answer pulse stands only from the edge after the request to the next edge
        while (n < 4 && ans[17] !== 1'b1) begin
            if (rd_valid_q === 1'b1)
                ans = {1'b1, rd_err_q, rd_data_q};
            else
                @(negedge clk);
            n++;
        end
    endtask
endmodule

// >>> test_alarm_status_trend_readout.sv
// Self-checking bench of the alarm status and trend readout block
module test_alarm_status_trend_readout;
    timeunit 1ns;
    timeprecision 1ps;
    import trend_readout_pkg::*;

    logic               clk;
    logic               rst;
    logic               alarm_insul;
    logic               alarm_prevent;
    logic               alarm_transient;
    logic               alarm_acked;
    logic [NUM_RES-1:0] rec_push;
    logic [31:0]        rec_value;
    logic [2:0]         rec_state;
    logic               rd_req;
    logic [15:0]        rd_addr;
    logic [15:0]        rd_data_q;
    logic               rd_valid_q;
    logic               rd_err_q;
    int                 miscompares;
    int                 n_compared;
    int                 cycles;
    int                 gap;

    ////////////////////////////////////////////////////////////
    // Design and polling master
    alarm_status_trend_readout i_dut (
        .clk(clk), .rst(rst), .alarm_insul(alarm_insul), .alarm_prevent(alarm_prevent),
        .alarm_transient(alarm_transient), .alarm_acked(alarm_acked), .rec_push(rec_push),
        .rec_value(rec_value), .rec_state(rec_state), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q)
    );
    master_poll_model i_master (
        .clk(clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q)
    );

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("timeout after %0d cycles", cycles);
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd(input string name, input logic [15:0] addr, input logic [15:0] exp, input logic err);
        logic [17:0] ans;
        i_master.read_reg(addr, gap, ans);
        check(name, {1'b1, err, exp}, ans);
    endtask

    task automatic push(input int r, input logic [31:0] v, input logic [2:0] s);
        @(negedge clk);
        rec_push  = NUM_RES'(1) << r;
        rec_value = v;
        rec_state = s;
        @(negedge clk);
        rec_push  = '0;
        rec_value = ~v;
    endtask

    // High word pops, then count, low word and status of that same record
    task automatic pop_check(input int r, input logic [31:0] v, input logic [2:0] s, input logic [15:0] cnt);
        rd("value_hi", VAL_OFS[r], v[31:16], 1'b0);
        rd("pending", CNT_OFS[r], cnt, 1'b0);
        rd("value_lo", VAL_OFS[r] + LO_STEP, v[15:0], 1'b0);
        rd("rec_state", ST_OFS[r], {13'h0000, s}, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        for (int r = 0; r < NUM_RES; r++) begin
            rd("pending", CNT_OFS[r], CNT_RST, 1'b0);
            rd("value_hi", VAL_OFS[r], VAL_RST[31:16], 1'b0);
            rd("rec_state", ST_OFS[r], {13'h0000, REC_UNINIT}, 1'b0);
        end
        rd("alarm", ALARM_OFS, ALARM_NONE, 1'b0);
        rd("hole_cnt", 16'h04b5, 16'h0000, 1'b1);
        rd("hole_end", 16'h04c9, 16'h0000, 1'b1);
        $display("test reset done");
    endtask

    // Several inputs high at once resolve to acknowledged first
    task automatic t_alarm;
        logic [3:0]  in_t [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9};
        logic [15:0] ex_t [6] = '{ALARM_NONE, ALARM_ACTIVE, ALARM_PREVENT, ALARM_TRANS, ALARM_ACKED, ALARM_ACKED};
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            {alarm_acked, alarm_transient, alarm_prevent, alarm_insul} = in_t[k];
            rd("alarm", ALARM_OFS, ex_t[k], 1'b0);
        end
        @(negedge clk);
        {alarm_acked, alarm_transient, alarm_prevent, alarm_insul} = 4'h0;
        $display("test alarm done");
    endtask

    // Two records per resolution; other counts must stay untouched, the week log is polled slowly
    task automatic t_trend;
        logic [31:0] va;
        logic [31:0] vb;
        logic [2:0]  sa;
        logic [2:0]  sb;
        for (int r = 0; r < NUM_RES; r++) begin
            va = {12'h3f8, 4'(r), 16'h1234};
            vb = {12'hc12, 4'(r), 16'h00a5};
            sa = 3'(2 * r % 6);
            sb = 3'((2 * r + 1) % 6);
            gap = (r == 2) ? 3 : 0;
            push(r, va, sa);
            push(r, vb, sb);
            for (int q = 0; q < NUM_RES; q++)
                rd("pending", CNT_OFS[q], (q == r) ? 16'h0002 : CNT_RST, 1'b0);
            pop_check(r, va, sa, 16'h0001);
            pop_check(r, vb, sb, 16'h0000);
            pop_check(r, vb, sb, 16'h0000);
        end
        gap = 0;
        $display("test trend done");
    endtask

    // Nine back-to-back pushes overflow the ring; the oldest is lost, then drain to empty
    task automatic t_overflow;
        @(negedge clk);
        for (int k = 0; k < 9; k++) begin
            rec_push  = NUM_RES'(1);
            rec_value = {16'h4100 + 16'(k), 16'h0000};
            rec_state = REC_INJ;
            @(negedge clk);
        end
        rec_push = '0;
        rd("pending", CNT_OFS[0], RING_FULL, 1'b0);
        for (int k = 1; k < 9; k++)
            pop_check(0, {16'h4100 + 16'(k), 16'h0000}, REC_INJ, 16'(8 - k));
        rd("pending", CNT_OFS[0], CNT_RST, 1'b0);
        $display("test overflow done");
    endtask

    ////////////////////////////////////////////////////////////
    // Closing report
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {alarm_acked, alarm_transient, alarm_prevent, alarm_insul} = 4'h0;
        rec_push = '0;
        rec_value = 32'h0000_0000;
        rec_state = 3'h0;
        miscompares = 0;
        n_compared = 0;
        cycles = 0;
        gap = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_alarm();
        t_trend();
        t_overflow();
        give_verdict();
    end
endmodule

// >>> trend_readout_pkg.sv
// Register map, code values and storage sizes of the alarm and trend readout block
package trend_readout_pkg;

    // Number of trend resolutions: hour, day, week, month, year
    localparam int NUM_RES = 5;

    // Register numbers as seen by the polling master
    localparam logic [15:0] ALARM_OFS = 16'h044c;
    localparam logic [15:0] CNT_OFS [NUM_RES] = '{16'h04b0, 16'h04b1, 16'h04b2, 16'h04b3, 16'h04b4};
    localparam logic [15:0] VAL_OFS [NUM_RES] = '{16'h04ba, 16'h04bd, 16'h04c0, 16'h04c3, 16'h04c6};
    localparam logic [15:0] ST_OFS  [NUM_RES] = '{16'h04bc, 16'h04bf, 16'h04c2, 16'h04c5, 16'h04c8};
    localparam logic [15:0] LO_STEP = 16'h0001;

    // Alarm status codes
    localparam logic [15:0] ALARM_NONE    = 16'h0000;
    localparam logic [15:0] ALARM_ACTIVE  = 16'h0001;
    localparam logic [15:0] ALARM_PREVENT = 16'h0002;
    localparam logic [15:0] ALARM_TRANS   = 16'h0004;
    localparam logic [15:0] ALARM_ACKED   = 16'h0008;

    // Record status codes
    localparam logic [2:0] REC_UNINIT     = 3'h0;
    localparam logic [2:0] REC_INVALID    = 3'h1;
    localparam logic [2:0] REC_VALID      = 3'h2;
    localparam logic [2:0] REC_SUPPLY     = 3'h3;
    localparam logic [2:0] REC_INJ        = 3'h4;
    localparam logic [2:0] REC_SUPPLY_INJ = 3'h5;

    // Record storage per resolution
    localparam int          RING_DEPTH = 8;
    localparam int          PTR_W      = 3;
    localparam logic [15:0] RING_FULL  = 16'h0008;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [31:0] VAL_RST    = 32'h0000_0000;

endpackage

// >>> trend_record_store.sv
// Ring of unread trend records for one resolution, with its pending count
module trend_record_store (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        push,
    input  wire logic [31:0] push_value,
    input  wire logic [2:0]  push_state,
    input  wire logic        pop,
    output logic [31:0]      head_value,
    output logic [2:0]       head_state,
    output logic [15:0]      count_q
);
    import trend_readout_pkg::*;

    logic [31:0]      val_q [RING_DEPTH];
    logic [2:0]       st_q  [RING_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic             do_pop;
    logic             drop;

    // A pop on an empty ring does nothing, so the count never wraps
    // empty pop ignored
    assign do_pop = pop && (count_q != CNT_RST);
    // When full, a new record pushes out the oldest unread one
    assign drop   = push && !do_pop && (count_q == RING_FULL);
    assign head_value = val_q[rd_ptr_q];
    assign head_state = st_q[rd_ptr_q];

    // Record storage, written at the tail
    always_ff @(posedge clk) begin
        if (push) begin
            val_q[wr_ptr_q] <= push_value;
            st_q[wr_ptr_q]  <= push_state;
        end
    end

    // Pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop || drop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // Pending count: up on push, down on a real pop, held on both or on a drop
    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= CNT_RST;
        end else if (push && !do_pop && !drop) begin
            count_q <= count_q + 16'h0001;
        end else if (do_pop && !push) begin
            count_q <= count_q - 16'h0001;
        end
    end

endmodule
